// ---- rtl/adc_config_pkg.sv ----
// constants for the converter configuration register bank
// assumes a single 20 MHz clock; serial link pins are sampled, not used as clocks
package adc_config_pkg;
  // register map: byte addresses of each 32-bit register
  localparam int          REG_COUNT        = 9;
  localparam logic [8:0]  OFF_DEVICE_ID    = 9'h000;
  localparam logic [8:0]  OFF_RESET_POWER  = 9'h004;
  localparam logic [8:0]  OFF_INPUT_CTL    = 9'h008;
  localparam logic [8:0]  OFF_OUTPUT_CTL   = 9'h00C;
  localparam logic [8:0]  OFF_DATA_CTL     = 9'h010;
  localparam logic [8:0]  OFF_RANGE_SEL    = 9'h014;
  localparam logic [8:0]  OFF_ALARM_STAT   = 9'h020;
  localparam logic [8:0]  OFF_ALARM_HIGH   = 9'h024;
  localparam logic [8:0]  OFF_ALARM_LOW    = 9'h028;
  // storage indices
  localparam logic [3:0]  IDX_DEVICE_ID    = 4'h0;
  localparam logic [3:0]  IDX_RESET_POWER  = 4'h1;
  localparam logic [3:0]  IDX_INPUT_CTL    = 4'h2;
  localparam logic [3:0]  IDX_OUTPUT_CTL   = 4'h3;
  localparam logic [3:0]  IDX_DATA_CTL     = 4'h4;
  localparam logic [3:0]  IDX_RANGE_SEL    = 4'h5;
  localparam logic [3:0]  IDX_ALARM_STAT   = 4'h6;
  localparam logic [3:0]  IDX_ALARM_HIGH   = 4'h7;
  localparam logic [3:0]  IDX_ALARM_LOW    = 4'h8;
  // writable bits per register, index 8 first
  localparam logic [REG_COUNT-1:0][31:0] WRITE_MASK = {
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'h0000_1343, 32'h0000_0003, 32'h0000_FF37, 32'h000F_0000};
  // bits that survive an application reset, index 8 first
  localparam logic [REG_COUNT-1:0][31:0] APP_KEEP_MASK = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0043, 32'h0000_0000, 32'h0000_0006, 32'h0000_0000};
  localparam logic [31:0] REG_RESET_VALUE  = 32'h0000_0000;
  // reset and power control fields
  localparam int          POS_KEY_LSB      = 8;
  localparam int          POS_SUPPLY_DIS   = 5;
  localparam int          POS_INPUT_DIS    = 4;
  localparam int          POS_PIN_CLASS    = 2;
  localparam int          POS_SLEEP_EN     = 1;
  localparam int          POS_POWER_DOWN   = 0;
  localparam logic [7:0]  UNLOCK_KEY       = 8'h69;
  // serial input control: clock polarity and phase
  localparam int          POS_CPHA         = 0;
  localparam int          POS_CPOL         = 1;
  // serial output control fields
  localparam int          POS_GPO_VALUE    = 12;
  localparam int          POS_LANE1_LSB    = 8;
  localparam logic [1:0]  LANE1_OFF        = 2'h0;
  localparam logic [1:0]  LANE1_ALARM      = 2'h1;
  localparam logic [1:0]  LANE1_GPO        = 2'h2;
  localparam logic [1:0]  LANE1_DATA       = 2'h3;
  // frame layout: command, address, data
  localparam int          FRAME_BITS       = 32;
  localparam logic [5:0]  FRAME_MIN_BITS   = 6'h20;
  localparam int          POS_CMD_LSB      = 25;
  localparam int          POS_ADDR_LSB     = 16;
  localparam logic [6:0]  CMD_WRITE_BYTE   = 7'h68;
  localparam logic [6:0]  CMD_READ_WORD    = 7'h48;
endpackage : adc_config_pkg

// ---- rtl/adc_config_register_bank.sv ----
// configuration register bank of a serial converter, reached over a clock/select link
// assumes link pins are asynchronous and much slower than clock (sclk under clock/4)
// What this block does
// - nine registers at documented byte addresses
// - each register spans four bytes, LSB first
// - identity holds 4-bit device address, reset zero
// - reserved bits read-only, always read zero
// - key field 15-8; bits 5-0 need key
// - bit 5 disables supply alarm
// - bit 4 disables input alarm
// - bit 2 turns reset pin into application reset
// - bit 1 allows nap when select stays high
// - bit 0 requests power-down
// - bits 2,1 survive application reset only
// - one and two lane output share timing
// - after reset only mode zero link accepted
`timescale 1ns/1ps
module adc_config_register_bank (
  // clock and power-on reset
  input  wire logic        clock,
  input  wire logic        reset,
  // serial link pins, asynchronous
  input  wire logic        serial_clock,
  input  wire logic        convert_start_select,
  input  wire logic        serial_data_in,
  input  wire logic        reset_pin_n,
  // converter status from core logic
  input  wire logic        conversion_busy,
  input  wire logic        alarm_active,
  input  wire logic [31:0] alarm_flags,
  // serial outputs
  output logic             data_lane0,
  output logic             data_lane0_enable,
  output logic             data_lane1,
  output logic             data_lane1_enable,
  // converter controls
  output logic             supply_alarm_disable,
  output logic             input_alarm_disable,
  output logic             reset_pin_class_select,
  output logic             light_sleep_enable,
  output logic             light_sleep_active,
  output logic             power_down_request,
  output logic [3:0]       device_address
);
  import adc_config_pkg::*;

  typedef struct packed {
    logic [REG_COUNT-1:0][31:0] regs;        // register storage
    logic                       sclk_prev;   // last synced serial clock
    logic                       select_prev; // last synced select
    logic [FRAME_BITS-1:0]      shift_in;    // captured frame
    logic [5:0]                 bit_count;   // saturates at frame size
    logic [FRAME_BITS-1:0]      shift_out;   // word going out
    logic [FRAME_BITS-1:0]      read_word;   // loaded at the end of a read frame, shifted out from the next frame start
    logic                       launched;    // first launch edge seen
    logic                       lane0;
    logic                       lane1;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;

  // synced pins
  logic sclk_sync;
  logic select_sync;
  logic sdi_sync;
  logic pin_reset_n_sync;

  pin_synchronizer sync_sclk (
    .clock       (clock),
    .reset       (reset),
    .pin_async   (serial_clock),
    .reset_level (1'b0),
    .pin_sync    (sclk_sync)
  );
  pin_synchronizer sync_select (
    .clock       (clock),
    .reset       (reset),
    .pin_async   (convert_start_select),
    .reset_level (1'b1),
    .pin_sync    (select_sync)
  );
  pin_synchronizer sync_sdi (
    .clock       (clock),
    .reset       (reset),
    .pin_async   (serial_data_in),
    .reset_level (1'b0),
    .pin_sync    (sdi_sync)
  );
  pin_synchronizer sync_pin_reset (
    .clock       (clock),
    .reset       (reset),
    .pin_async   (reset_pin_n),
    .reset_level (1'b1),
    .pin_sync    (pin_reset_n_sync)
  );

  // byte address to storage index; only mapped words answer
  function automatic logic [4:0] decode_index(input logic [8:0] addr);
    logic [8:0] base;
    base = {addr[8:2], 2'b00};
    if (base == OFF_DEVICE_ID)        decode_index = {1'b1, IDX_DEVICE_ID};
    else if (base == OFF_RESET_POWER) decode_index = {1'b1, IDX_RESET_POWER};
    else if (base == OFF_INPUT_CTL)   decode_index = {1'b1, IDX_INPUT_CTL};
    else if (base == OFF_OUTPUT_CTL)  decode_index = {1'b1, IDX_OUTPUT_CTL};
    else if (base == OFF_DATA_CTL)    decode_index = {1'b1, IDX_DATA_CTL};
    else if (base == OFF_RANGE_SEL)   decode_index = {1'b1, IDX_RANGE_SEL};
    else if (base == OFF_ALARM_STAT)  decode_index = {1'b1, IDX_ALARM_STAT};
    else if (base == OFF_ALARM_HIGH)  decode_index = {1'b1, IDX_ALARM_HIGH};
    else if (base == OFF_ALARM_LOW)   decode_index = {1'b1, IDX_ALARM_LOW};
    else                              decode_index = 5'h00;
  endfunction : decode_index

  // combinational helpers
  logic        cpol;
  logic        cpha;
  logic        sclk_edge;
  logic        capture_edge;
  logic        launch_edge;
  logic        frame_start;
  logic        frame_end;
  logic        dual_lane;
  logic [1:0]  lane1_mode;
  logic [6:0]  frame_cmd;
  logic [8:0]  frame_addr;
  logic [7:0]  frame_byte;
  logic [4:0]  hit;
  logic [3:0]  idx;
  logic [31:0] byte_mask;
  logic [31:0] new_word;
  logic [31:0] allowed;
  logic [31:0] old_word;

  // mode bits come from the stored register, so a mode write acts from the next frame
  assign cpol         = state_reg.regs[IDX_INPUT_CTL][POS_CPOL];
  assign cpha         = state_reg.regs[IDX_INPUT_CTL][POS_CPHA];
  assign sclk_edge    = (sclk_sync != state_reg.sclk_prev) && !select_sync;
  // capture on rising when polarity equals phase, falling otherwise
  assign capture_edge = sclk_edge && (sclk_sync == (cpol == cpha));
  assign launch_edge  = sclk_edge && (sclk_sync != (cpol == cpha));
  assign frame_start  = state_reg.select_prev && !select_sync;
  assign frame_end    = !state_reg.select_prev && select_sync;
  assign lane1_mode   = state_reg.regs[IDX_OUTPUT_CTL][POS_LANE1_LSB +: 2];
  assign dual_lane    = (lane1_mode == LANE1_DATA);
  assign frame_cmd    = state_reg.shift_in[POS_CMD_LSB +: 7];
  assign frame_addr   = state_reg.shift_in[POS_ADDR_LSB +: 9];
  assign frame_byte   = state_reg.shift_in[7:0];
  assign hit          = decode_index(frame_addr);
  assign idx          = hit[3:0];

  // next state: link shifting, frame decode, resets
  always_comb
  begin
    state_next             = state_reg;
    state_next.sclk_prev   = sclk_sync;
    state_next.select_prev = select_sync;
    byte_mask              = 32'h0000_00FF << {frame_addr[1:0], 3'b000};
    new_word               = {4{frame_byte}} & byte_mask;
    old_word               = state_reg.regs[idx];
    // reserved bits never take a write
    allowed                = byte_mask & WRITE_MASK[idx];
    // low control bits only move once the key is in place
    if ((idx == IDX_RESET_POWER)
        && (state_reg.regs[IDX_RESET_POWER][POS_KEY_LSB +: 8] != UNLOCK_KEY))
    begin
      allowed = allowed & 32'hFFFF_FF00;
    end

    // frame start: reset counters and present the pending read word
    if (frame_start)
    begin
      state_next.bit_count = 6'h00;
      state_next.shift_out = state_reg.read_word;
      state_next.launched  = 1'b0;
      state_next.lane0     = state_reg.read_word[FRAME_BITS-1];
      state_next.lane1     = state_reg.read_word[FRAME_BITS-2];
    end
    else if (capture_edge)
    begin
      state_next.shift_in = {state_reg.shift_in[FRAME_BITS-2:0], sdi_sync};
      if (state_reg.bit_count != FRAME_MIN_BITS)
      begin
        state_next.bit_count = state_reg.bit_count + 6'h01;
      end
    end
    else if (launch_edge)
    begin
      // phase-one modes launch the first bit on the first edge, no shift then
      if (cpha && !state_reg.launched)
      begin
        state_next.launched = 1'b1;
      end
      else if (dual_lane)
      begin
        // two bits per edge; edge timing is the same as one lane
        state_next.shift_out = {state_reg.shift_out[FRAME_BITS-3:0], 2'b00};
        state_next.lane0     = state_reg.shift_out[FRAME_BITS-3];
        state_next.lane1     = state_reg.shift_out[FRAME_BITS-4];
      end
      else
      begin
        state_next.shift_out = {state_reg.shift_out[FRAME_BITS-2:0], 1'b0};
        state_next.lane0     = state_reg.shift_out[FRAME_BITS-2];
      end
    end

    // frame end: act only on full frames, short frames are dropped
    if (frame_end && (state_reg.bit_count == FRAME_MIN_BITS))
    begin
      if ((frame_cmd == CMD_WRITE_BYTE) && hit[4])
      begin
        state_next.regs[idx] = (old_word & ~allowed) | (new_word & allowed);
        if (idx == IDX_RESET_POWER)
        begin
          // once the pin is an application reset it stays so until power cycles
          state_next.regs[idx][POS_PIN_CLASS] = old_word[POS_PIN_CLASS]
                                               | state_next.regs[idx][POS_PIN_CLASS];
        end
      end
      else if (frame_cmd == CMD_READ_WORD)
      begin
        // unmapped words read as zero
        state_next.read_word = hit[4] ? state_reg.regs[idx] : REG_RESET_VALUE;
        if (hit[4] && (idx == IDX_ALARM_STAT))
        begin
          state_next.read_word = alarm_flags;
        end
      end
    end

    // reset pin: full clear or application clear depending on class bit
    if (!pin_reset_n_sync)
    begin
      state_next.read_word = REG_RESET_VALUE;
      state_next.bit_count = 6'h00;
      for (int i = 0; i < REG_COUNT; i++)
      begin
        if (state_reg.regs[IDX_RESET_POWER][POS_PIN_CLASS])
        begin
          state_next.regs[i] = state_reg.regs[i] & APP_KEEP_MASK[i];
        end
        else
        begin
          state_next.regs[i] = REG_RESET_VALUE;
        end
      end
    end
  end

  // power-on reset clears everything, key and identity included
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= '{regs: '0, sclk_prev: 1'b0, select_prev: 1'b1, shift_in: '0,
                     bit_count: 6'h00, shift_out: '0, read_word: '0,
                     launched: 1'b0, lane0: 1'b0, lane1: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // lane outputs: lane 1 is off, alarm, general output or second data bit
  always_comb
  begin
    data_lane0        = state_reg.lane0;
    data_lane0_enable = !select_sync;
    data_lane1        = 1'b0;
    data_lane1_enable = 1'b0;
    if (lane1_mode == LANE1_ALARM)
    begin
      data_lane1        = alarm_active;
      data_lane1_enable = 1'b1;
    end
    else if (lane1_mode == LANE1_GPO)
    begin
      data_lane1        = state_reg.regs[IDX_OUTPUT_CTL][POS_GPO_VALUE];
      data_lane1_enable = 1'b1;
    end
    else if (lane1_mode == LANE1_DATA)
    begin
      data_lane1        = state_reg.lane1;
      data_lane1_enable = !select_sync;
    end
  end

  // control outputs straight from storage
  assign supply_alarm_disable   = state_reg.regs[IDX_RESET_POWER][POS_SUPPLY_DIS];
  assign input_alarm_disable    = state_reg.regs[IDX_RESET_POWER][POS_INPUT_DIS];
  assign reset_pin_class_select = state_reg.regs[IDX_RESET_POWER][POS_PIN_CLASS];
  assign light_sleep_enable     = state_reg.regs[IDX_RESET_POWER][POS_SLEEP_EN];
  assign power_down_request     = state_reg.regs[IDX_RESET_POWER][POS_POWER_DOWN];
  assign device_address         = state_reg.regs[IDX_DEVICE_ID][POS_ADDR_LSB +: 4];
  // nap once the conversion is over and select is still high
  assign light_sleep_active     = light_sleep_enable && select_sync
                                  && !conversion_busy;
endmodule : adc_config_register_bank

// ---- rtl/pin_synchronizer.sv ----
// two-stage synchronizer for one pin coming from outside the clock domain
// assumes clock is free running; output lags the pin by two edges
`timescale 1ns/1ps
module pin_synchronizer (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // pin side
  input  wire logic pin_async,
  input  wire logic reset_level,
  // logic side
  output logic      pin_sync
);
  typedef struct packed {
    logic first;   // metastable stage, read only by second
    logic second;  // safe copy
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // shift the pin through both stages, stored relative to the reset level
  always_comb
  begin
    state_next.first  = pin_async ^ reset_level;
    state_next.second = state_reg.first;
  end

  // flops clear to zero; the output flip below turns that into the reset level
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= '{first: 1'b0, second: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // undo the level offset: the pin passes unchanged, reset shows reset_level
  assign pin_sync = state_reg.second ^ reset_level;
endmodule : pin_synchronizer

// ---- sim/adc_config_register_bank_props.sv ----
// checker for the configuration register bank, bound to its top module
// assumes one clock domain and the asynchronous, active-high power-on reset
`timescale 1ns/1ps
module adc_config_register_bank_props (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // pins and core status
  input  wire logic        convert_start_select,
  input  wire logic        reset_pin_n,
  input  wire logic        conversion_busy,
  // outputs watched
  input  wire logic        data_lane0_enable,
  input  wire logic        supply_alarm_disable,
  input  wire logic        input_alarm_disable,
  input  wire logic        reset_pin_class_select,
  input  wire logic        light_sleep_enable,
  input  wire logic        light_sleep_active,
  input  wire logic        power_down_request,
  input  wire logic [3:0]  device_address
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic [4:0] ctrl;  // control bits of the reset and power register
  assign ctrl = {supply_alarm_disable, input_alarm_disable, reset_pin_class_select,
                 light_sleep_enable, power_down_request};
  // registers move once a frame has closed, or when the reset pin clears them
  AST_CTRL_AFTER_FRAME: assert property ($changed(ctrl) |-> $past(convert_start_select, 2))
    else $error("control bits changed inside a frame");
  AST_ADDR_AFTER_FRAME: assert property ($changed(device_address) |-> $past(convert_start_select, 2))
    else $error("device address changed inside a frame");
  AST_SLEEP_NEEDS_ENABLE: assert property (light_sleep_active |-> light_sleep_enable && !conversion_busy)
    else $error("sleep active without enable or while busy");
  AST_SLEEP_WHEN_IDLE: assert property ((light_sleep_enable && !conversion_busy && convert_start_select) [*5] |-> light_sleep_active)
    else $error("sleep not entered with select held high");
  AST_LANE0_IDLE_OFF: assert property (convert_start_select [*5] |-> !data_lane0_enable)
    else $error("lane 0 driven outside a frame");
  AST_APP_RESET: assert property ((!reset_pin_n && reset_pin_class_select) [*5] |-> reset_pin_class_select && ctrl[4:3] == 2'b00 && !power_down_request && device_address == 4'h0)
    else $error("application reset cleared the wrong fields");
  AST_FULL_PIN_RESET: assert property ((!reset_pin_n && !reset_pin_class_select) [*5] |-> ctrl == 5'h00 && device_address == 4'h0)
    else $error("pin reset did not clear everything");
  AST_POR_CLEAR: assert property (disable iff (1'b0) reset |-> ctrl == 5'h00 && device_address == 4'h0)
    else $error("power-on reset left a field set");
  AST_CLASS_STICKY: assert property (!$fell(reset_pin_class_select))
    else $error("reset class bit cleared without power-on reset");
  // main scenarios reached
  COVER_ALL_SET: cover property (ctrl == 5'h1f);
  COVER_APP_RESET: cover property (!reset_pin_n && reset_pin_class_select);
  COVER_SLEEP: cover property (light_sleep_active);
endmodule : adc_config_register_bank_props

bind adc_config_register_bank adc_config_register_bank_props u_props (
  .clock(clock), .reset(reset), .convert_start_select(convert_start_select),
  .reset_pin_n(reset_pin_n), .conversion_busy(conversion_busy),
  .data_lane0_enable(data_lane0_enable), .supply_alarm_disable(supply_alarm_disable),
  .input_alarm_disable(input_alarm_disable), .reset_pin_class_select(reset_pin_class_select),
  .light_sleep_enable(light_sleep_enable), .light_sleep_active(light_sleep_active),
  .power_down_request(power_down_request), .device_address(device_address));

// ---- sim/adc_config_register_bank_tb.sv ----
// self-checking bench for the configuration register bank and its host link
// assumes the host model for link frames; read words are checked from a queue
`timescale 1ns/1ps
module adc_config_register_bank_tb;
  import adc_config_pkg::*;
  logic        clock, reset, sclk, sel, sdi, lane0, reset_pin_n, busy;
  logic        lane1, lane1_en, alarm_act, dual;
  logic        sup_dis, in_dis, pin_class, sleep_en, sleep_act, pdn;
  logic [3:0]  dev_addr;
  logic [31:0] alarm_flags, rnd;
  logic [31:0] exp_q[$];  // read words still to come
  int          err_total, checks, i;
  adc_config_register_bank u_dut (
    .clock(clock), .reset(reset), .serial_clock(sclk), .convert_start_select(sel),
    .serial_data_in(sdi), .reset_pin_n(reset_pin_n), .conversion_busy(busy),
    .alarm_active(alarm_act), .alarm_flags(alarm_flags), .data_lane0(lane0),
    .data_lane0_enable(), .data_lane1(lane1), .data_lane1_enable(lane1_en),
    .supply_alarm_disable(sup_dis), .input_alarm_disable(in_dis),
    .reset_pin_class_select(pin_class), .light_sleep_enable(sleep_en),
    .light_sleep_active(sleep_act), .power_down_request(pdn), .device_address(dev_addr));
  link_host_model u_host (
    .clock(clock), .serial_clock(sclk), .convert_start_select(sel),
    .serial_data_in(sdi), .data_lane0(lane0), .data_lane1(lane1), .word_seen(),
    .pair_seen());
  always #25 clock = ~clock;
  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : next_rnd
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick
  task automatic tally(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : tally
  task automatic compare_word(input logic [31:0] exp);
    tally(dual ? u_host.pair_seen : u_host.word_seen, exp, "read word");
  endtask : compare_word
  // lane 1 packed as level, enable
  task automatic compare_lane1(input logic [1:0] e);
    tally({30'h0, lane1, lane1_en}, {30'h0, e}, "lane 1");
  endtask : compare_lane1
  // pins packed as supply, input, class, sleep, active, power-down
  task automatic compare_pins(input logic [5:0] e, input logic [3:0] a);
    tally({22'h0, sup_dis, in_dis, pin_class, sleep_en, sleep_act, pdn, dev_addr},
          {22'h0, e, a}, "pins");
  endtask : compare_pins
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    u_host.xfer({CMD_WRITE_BYTE, a, 8'h00, d}, 32, 1'b0);
  endtask : wr
  // read needs a second frame to shift the word out
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    u_host.xfer({CMD_READ_WORD, a, 16'h0000}, 32, 1'b0);
    // two lanes empty the word in 16 clocks
    u_host.xfer(32'h0000_0000, dual ? 16 : 32, 1'b1);
  endtask : rd
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // oldest expectation meets each word the host brings back
  always @(u_host.word_ev)
    compare_word(exp_q.pop_front());
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clock);
    err_total++;
    complete_run();
  end
  initial
  begin
    logic [8:0] regs[4];
    regs = '{9'h010, 9'h014, 9'h024, 9'h028};
    clock = 1'b0;
    reset = 1'b1;
    reset_pin_n = 1'b1;
    busy = 1'b0;
    alarm_flags = 32'h0000_0000;
    alarm_act = 1'b1;
    dual = 1'b0;
    rnd = 32'h0000_5c49;
    err_total = 0;
    checks = 0;
    tick(12);
    reset = 1'b0;
    tick(4);
    compare_pins(6'h00, 4'h0);
    rd(9'h004, 32'h0000_0000);
    rd(9'h000, 32'h0000_0000);
    wr(9'h004, 8'hff);
    compare_pins(6'h00, 4'h0);
    wr(9'h005, UNLOCK_KEY);
    wr(9'h004, 8'hff);
    compare_pins(6'h3f, 4'h0);
    rd(9'h004, 32'h0000_6937);
    wr(9'h002, 8'hff);
    compare_pins(6'h3f, 4'hf);
    rd(9'h000, 32'h000f_0000);
    u_host.xfer({CMD_WRITE_BYTE, 9'h002, 16'h0005}, 31, 1'b0);
    compare_pins(6'h3f, 4'hf);
    busy = 1'b1;
    #1;
    compare_pins(6'h3d, 4'hf);
    tick(1);
    busy = 1'b0;
    reset_pin_n = 1'b0;
    tick(8);
    reset_pin_n = 1'b1;
    tick(4);
    compare_pins(6'h0e, 4'h0);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(4);
    compare_pins(6'h00, 4'h0);
    wr(9'h005, UNLOCK_KEY);
    wr(9'h004, 8'h02);
    compare_pins(6'h06, 4'h0);
    reset_pin_n = 1'b0;
    tick(8);
    reset_pin_n = 1'b1;
    tick(4);
    compare_pins(6'h00, 4'h0);
    // random byte into a random lane of each plain register
    for (i = 0; i < 4; i++)
    begin
      rnd = next_rnd(rnd);
      wr(regs[i] + {7'h00, rnd[1:0]}, rnd[15:8]);
      rd(regs[i], {24'h00_0000, rnd[15:8]} << (8 * rnd[1:0]));
    end
    // other clock modes, each selected by a frame in the mode before it
    for (i = 1; i < 4; i++)
    begin
      wr(9'h008, 8'(i));
      u_host.set_mode(2'(i));
      rd(9'h008, 32'(i));
    end
    wr(9'h008, 8'h00);
    u_host.set_mode(2'b00);
    // lane 1 as general output, as alarm, then as second data lane
    wr(9'h00d, 8'h12);
    compare_lane1(2'b11);
    wr(9'h00d, 8'h01);
    alarm_act = 1'b0;
    #1;
    compare_lane1(2'b01);
    wr(9'h00d, 8'h03);
    dual = 1'b1;
    rd(9'h00c, 32'h0000_0300);
    wr(9'h00d, 8'h00);
    dual = 1'b0;
    wr(9'h018, 8'h5a);
    rd(9'h018, 32'h0000_0000);
    rnd = next_rnd(rnd);
    alarm_flags = rnd;
    wr(9'h020, 8'hff);
    rd(9'h020, rnd);
    tick(4);
    complete_run();
  end
endmodule : adc_config_register_bank_tb

// ---- sim/link_host_model.sv ----
// host side of the serial link: select, clock and data frames in any of the four clock modes
// assumes the bench clock; pins change 2 ns after a rising clock edge
`timescale 1ns/1ps
module link_host_model (
  // clock
  input  wire logic        clock,
  // link pins
  output logic             serial_clock,
  output logic             convert_start_select,
  output logic             serial_data_in,
  input  wire logic        data_lane0,
  input  wire logic        data_lane1,
  // word shifted in from lane 0, and from both lanes in pairs
  output logic [31:0]      word_seen,
  output logic [31:0]      pair_seen
);
  event       word_ev;    // fires after a frame whose word is wanted
  logic [1:0] link_mode;  // polarity, phase of the frames to come
  // idle: select high, link clock parked low
  initial
  begin
    serial_clock         = 1'b0;
    convert_start_select = 1'b1;
    serial_data_in       = 1'b0;
    word_seen            = 32'h0000_0000;
    pair_seen            = 32'h0000_0000;
    link_mode            = 2'b00;
  end
  // new mode: park the link clock at its idle level while select is high
  task automatic set_mode(input logic [1:0] m);
    link_mode    = m;
    serial_clock = m[1];
  endtask : set_mode
  // take what the lanes show
  task automatic sample;
    word_seen = {word_seen[30:0], data_lane0};
    pair_seen = {pair_seen[29:0], data_lane0, data_lane1};
  endtask : sample
  // half period, kept long so the two-flop pin sampling sees every level
  task automatic half;
    repeat (5) @(posedge clock);
    #2;
  endtask : half
  // one frame of n bits, msb first; phase 0 sets data before the leading edge
  task automatic xfer(input logic [31:0] w, input int n, input bit keep);
    int i;
    @(posedge clock);
    #2;
    convert_start_select = 1'b0;
    // fewer than 32 clocks when a refusal is wanted or for the 16-clock two-lane readout
    for (i = 0; i < n; i++)
    begin
      if (!link_mode[0])
        serial_data_in = w[31-i];
      half();
      serial_clock = ~link_mode[1];  // leading edge
      if (link_mode[0])
        serial_data_in = w[31-i];
      else
        sample();
      half();
      serial_clock = link_mode[1];  // trailing edge
      if (link_mode[0])
        sample();
    end
    half();
    convert_start_select = 1'b1;
    serial_data_in       = ~serial_data_in;  // released line shows no stale bit
    repeat (2) half();  // gap so the frame takes effect first
    if (keep)
      -> word_ev;
  endtask : xfer
endmodule : link_host_model
